// ### test/scsr_spi_host.sv
`timescale 1ns/1ps
// serial host model: mode 0, msb first, 16 core cycles per bit
module scsr_spi_host (
   input  wire logic core_clk_i,
   output logic      spi_sclk_o,
   output logic      spi_cs_n_o,
   output logic      spi_sdi_o,
   input  wire logic spi_sdo_i,
   input  wire logic spi_sdo_oe_n_i
);
   // idle: deselected, clock low, no edges outside frames
   initial begin
      spi_sclk_o = 1'b0;
      spi_cs_n_o = 1'b1;
      spi_sdi_o  = 1'b0;
   end

   // all pin changes land just after a core edge
   task automatic step(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask : step

   // one bit: data set while the clock is low, sampled at the rise
   task automatic shift_bit(input logic d, output logic q);
      spi_sdi_o = d;
      step(8);
      // a released output must not read as data
      q = (spi_sdo_oe_n_i === 1'b0) ? spi_sdo_i : 1'bx;
      spi_sclk_o = 1'b1;
      step(8);
      spi_sclk_o = 1'b0;
   endtask : shift_bit

   // whole frame: header {rd, addr} then n streamed bytes
   task automatic xfer(input logic rd, input logic [14:0] addr, input int n,
                       input logic [7:0] wd [4], output logic [7:0] rq [4]);
      logic [15:0] hdr;
      logic        q;
      int          i;
      hdr = {rd, addr};
      spi_cs_n_o = 1'b0;
      step(8);
      for (i = 0; i < 16; i++) begin
         shift_bit(hdr[15-i], q);
      end
      for (i = 0; i < 8 * n; i++) begin
         shift_bit(wd[i/8][7-i%8], q);
         rq[i/8][7-i%8] = q;
      end
      step(8);
      spi_cs_n_o = 1'b1;
      // released line shows the inverse so stale data cannot pass
      spi_sdi_o = ~spi_sdi_o;
      step(8);
   endtask : xfer
endmodule : scsr_spi_host

// ### test/spi_cfg_sysref_ctrl_regs_tb_top.sv
`timescale 1ns/1ps
module spi_cfg_sysref_ctrl_regs_tb_top;
   import scsr_pkg::*;
   logic       core_clk_i;
   logic       arst_n_i;
   logic       spi_sclk;
   logic       spi_cs_n;
   logic       spi_sdi;
   logic       spi_sdo;
   logic       spi_sdo_oe_n;
   logic       sysref;
   logic       ots;        // separate output timestamp enable
   logic [7:0] sample_in;
   logic [7:0] sample_out;
   logic       sr_event;
   logic       recv_en;
   logic       devclk_dc;
   logic       sr_dc;
   int         fails;
   int         num_checks;
   int         d0;         // coarse, select 0 latency
   int         dly;
   int         evs;

   scsr_spi_host host (.core_clk_i(core_clk_i), .spi_sclk_o(spi_sclk), .spi_cs_n_o(spi_cs_n),
      .spi_sdi_o(spi_sdi), .spi_sdo_i(spi_sdo), .spi_sdo_oe_n_i(spi_sdo_oe_n));

   scsr_spi_regs dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .spi_sclk_i(spi_sclk),
      .spi_cs_n_i(spi_cs_n), .spi_sdi_i(spi_sdi), .spi_sdo_o(spi_sdo),
      .spi_sdo_oe_n_o(spi_sdo_oe_n), .sysref_i(sysref), .output_timestamp_enable_i(ots),
      .sample_i(sample_in), .sample_o(sample_out), .sysref_event_o(sr_event),
      .sysref_receiver_enable_o(recv_en), .device_clock_dc_input_mode_o(devclk_dc),
      .sysref_dc_input_mode_o(sr_dc));

   // 250 MHz core clock
   initial begin
      core_clk_i = 1'b0;
      forever #2 core_clk_i = ~core_clk_i;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic final_report();
      $display("checks=%0d fails=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report

   // streamed write of one or two bytes
   task automatic wr(input logic [14:0] a, input int n, input logic [7:0] b0,
                     input logic [7:0] b1);
      logic [7:0] w [4];
      logic [7:0] r [4];
      w = '{b0, b1, 8'h00, 8'h00};
      host.xfer(1'b0, a, n, w, r);
   endtask : wr

   // streamed read of up to three bytes, compared in order
   task automatic rd(input logic [14:0] a, input int n, input logic [7:0] e0,
                     input logic [7:0] e1, input logic [7:0] e2);
      logic [7:0] w [4];
      logic [7:0] r [4];
      w = '{default: 8'h00};
      host.xfer(1'b1, a, n, w, r);
      check(r[0], e0);
      if (n > 1) check(r[1], e1);
      if (n > 2) check(r[2], e2);
   endtask : rd

   // two sync-ref pulses, 3 high then 5 low; latency of the lsb and event count
   task automatic sr_run(output int dl, output int ev);
      int t;
      dl = -1;
      ev = 0;
      for (t = 0; t < 120; t++) begin
         sysref = (t < 3) || (t >= 8 && t < 11);
         @(posedge core_clk_i);
         #1;
         if (dl < 0 && sample_out[0] === 1'b1) dl = t;
         if (sr_event === 1'b1) ev++;
      end
      check({1'b0, sample_out[7:1]}, {1'b0, sample_in[7:1]});
   endtask : sr_run

   initial begin
      arst_n_i   = 1'b0;
      sysref     = 1'b0;
      ots        = 1'b0;
      sample_in  = 8'hA4;
      fails      = 0;
      num_checks = 0;
      repeat (16) @(posedge core_clk_i);
      #1;
      arst_n_i = 1'b1;
      // let the pin synchronisers fill before the first frame
      repeat (10) @(posedge core_clk_i);
      #1;
      // reset values and outputs
      rd(ADDR_SRC, 1, 8'h00, 8'h00, 8'h00);
      rd(ADDR_CIC, 1, 8'h00, 8'h00, 8'h00);
      rd(ADDR_USR, 1, 8'h00, 8'h00, 8'h00);
      rd(ADDR_CFG_A, 1, 8'h30, 8'h00, 8'h00);
      check({5'h00, recv_en, devclk_dc, sr_dc}, 8'h00);
      // maker code is fixed, writes ignored; unmapped reads zero
      rd(ADDR_ID_LO, 2, MAKER_ID[7:0], MAKER_ID[15:8], 8'h00);
      wr(ADDR_ID_LO, 2, 8'h00, 8'h00);
      rd(ADDR_ID_LO, 2, MAKER_ID[7:0], MAKER_ID[15:8], 8'h00);
      rd(15'h0020, 1, 8'h00, 8'h00, 8'h00);
      // ascending stream; receiver set first
      wr(ADDR_SRC, 2, 8'h20, 8'h06);
      check({5'h00, recv_en, devclk_dc, sr_dc}, 8'h07);
      rd(ADDR_SRC, 2, 8'h20, 8'h06, 8'h00);
      // address hold keeps both bytes on one place
      wr(ADDR_USR, 1, 8'h01, 8'h00);
      wr(ADDR_SRC, 2, 8'h20, 8'h21);
      rd(ADDR_SRC, 2, 8'h21, 8'h21, 8'h00);
      wr(ADDR_USR, 1, 8'h00, 8'h00);
      rd(ADDR_CIC, 1, 8'h06, 8'h00, 8'h00);
      // descending stream
      wr(ADDR_CFG_A, 1, 8'h00, 8'h00);
      wr(ADDR_CIC, 2, 8'h02, 8'h20);
      rd(ADDR_SRC, 1, 8'h20, 8'h00, 8'h00);
      rd(ADDR_CFG_A, 1, 8'h10, 8'h00, 8'h00);
      check({5'h00, recv_en, devclk_dc, sr_dc}, 8'h05);
      wr(ADDR_CFG_A, 1, 8'h20, 8'h00);
      // reserved bits read zero; timestamp routing on
      wr(ADDR_CIC, 1, 8'hF8, 8'h00);
      rd(ADDR_CIC, 1, 8'h08, 8'h00, 8'h00);
      ots = 1'b1;
      sr_run(d0, evs);
      check(8'(evs), 8'h00);
      wr(ADDR_SRC, 1, 8'h63, 8'h00);
      sr_run(dly, evs);
      check(8'(dly), 8'(d0 + 6));
      check(8'(evs), 8'h02);
      wr(ADDR_SRC, 1, 8'h73, 8'h00);
      sr_run(dly, evs);
      check(8'(dly), 8'(d0 + 3));
      rd(ADDR_POS0, 3, 8'hE0, 8'h00, 8'h00);
      // one enable alone leaves the sample lsb alone
      ots = 1'b0;
      sr_run(dly, evs);
      check(8'(dly), 8'hFF);
      // polarity flip with the pin held low
      ots = 1'b1;
      wr(ADDR_CIC, 1, 8'h09, 8'h00);
      repeat (40) @(posedge core_clk_i);
      #1;
      check({7'h00, sample_out[0]}, 8'h01);
      wr(ADDR_SRC, 1, 8'h20, 8'h00);
      final_report();
   end
endmodule : spi_cfg_sysref_ctrl_regs_tb_top

// ### verilog/scsr_pin_sync.sv
`timescale 1ns/1ps
// three-stage pin synchroniser; a change is taken once stages two and
// three agree, which filters a single metastable sample
module scsr_pin_sync #(
   parameter int W = 4
) (
   input  wire logic         core_clk_i,
   input  wire logic         arst_n_i,
   input  wire logic [W-1:0] raw_i,
   output logic      [W-1:0] sync_o
);
   import scsr_pkg::*;

   typedef struct packed {
      logic [W-1:0] s1; // first stage, read only by s2
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;  // accepted level
   } scsr_sync_t;

   scsr_sync_t   r;
   scsr_sync_t   next_r;
   logic [W-1:0] next_q; // accepted level, next cycle

   // per-bit agreement filter: take the level only when the two later stages match
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         assign next_q[g] = (r.s2[g] == r.s3[g]) ? r.s3[g] : r.q[g];
      end
   endgenerate

   // shift the three stages and update the accepted level
   always_comb begin
      next_r    = r;
      next_r.s1 = raw_i;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      next_r.q  = next_q;
   end

   // single state register; all stages clear on reset
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign sync_o = r.q;
endmodule : scsr_pin_sync

// ### verilog/scsr_pkg.sv
package scsr_pkg;
   // byte addresses of the serial register map (15-bit address space)
   localparam logic [14:0] ADDR_CFG_A = 15'h0000; // address direction lives here
   localparam logic [14:0] ADDR_ID_LO = 15'h000C; // maker code, low byte
   localparam logic [14:0] ADDR_ID_HI = 15'h000D; // maker code, high byte
   localparam logic [14:0] ADDR_USR   = 15'h0010; // user serial config
   localparam logic [14:0] ADDR_SRC   = 15'h0029; // sync ref control
   localparam logic [14:0] ADDR_CIC   = 15'h002A; // clock input control
   localparam logic [14:0] ADDR_POS0  = 15'h002C; // position status, bits 7:0
   localparam logic [14:0] ADDR_POS1  = 15'h002D; // position status, bits 15:8
   localparam logic [14:0] ADDR_POS2  = 15'h002E; // position status, bits 23:16
   localparam logic [14:0] ADDR_STEP  = 15'h0001; // streaming address step

   // field positions
   localparam int CFG_A_ASCEND_BIT = 5;
   localparam int CFG_A_SDO_BIT    = 4;
   localparam int USR_HOLD_BIT     = 0;
   localparam int SRC_PROC_BIT     = 6;
   localparam int SRC_RECV_BIT     = 5;
   localparam int SRC_FINE_BIT     = 4;
   localparam int SRC_SEL_MSB      = 3;
   localparam int CIC_TS_BIT       = 3;
   localparam int CIC_DEVCLK_BIT   = 2;
   localparam int CIC_SRDC_BIT     = 1;
   localparam int CIC_FLIP_BIT     = 0;

   // reset values
   localparam logic       ASCEND_RST = 1'b1;
   localparam logic       HOLD_RST   = 1'b0;
   localparam logic [6:0] SRC_RST    = 7'h00;
   localparam logic [3:0] CIC_RST    = 4'h0;

   // maker code: value is arbitrary, not a real maker's code
   localparam logic [15:0] MAKER_ID = 16'hC35A;

   // frame and datapath sizes
   localparam logic [4:0] HDR_LAST  = 5'h0F; // 16 header bits
   localparam logic [4:0] BYTE_LAST = 5'h07; // 8 bits per data byte
   localparam int         POS_W     = 24;
   localparam int         HIST_W    = 48;
   localparam int         SAMPLE_W  = 8;

   // serial frame states, one-hot
   typedef enum logic [2:0] {
      SCSR_IDLE = 3'b001,
      SCSR_HDR  = 3'b010,
      SCSR_DATA = 3'b100
   } scsr_spi_st_t;
endpackage : scsr_pkg

// ### verilog/scsr_spi_regs.sv
`timescale 1ns/1ps
module scsr_spi_regs (
   input  wire logic                          core_clk_i,
   input  wire logic                          arst_n_i,
   input  wire logic                          spi_sclk_i,
   input  wire logic                          spi_cs_n_i,
   input  wire logic                          spi_sdi_i,
   output logic                               spi_sdo_o,
   output logic                               spi_sdo_oe_n_o,
   input  wire logic                          sysref_i,
   input  wire logic                          output_timestamp_enable_i,
   input  wire logic [scsr_pkg::SAMPLE_W-1:0] sample_i,
   output logic      [scsr_pkg::SAMPLE_W-1:0] sample_o,
   output logic                               sysref_event_o,
   output logic                               sysref_receiver_enable_o,
   output logic                               device_clock_dc_input_mode_o,
   output logic                               sysref_dc_input_mode_o
);
   import scsr_pkg::*;

   typedef struct packed {
      scsr_spi_st_t st;     // frame state
      logic         sclk_q; // serial clock, last cycle
      logic [4:0]   cnt;    // bit index in header or byte
      logic         rd;     // frame is a read
      logic [14:0]  addr;   // current register address
      logic [6:0]   rx;     // data bits received so far
      logic [7:0]   tx;     // read byte being shifted out
      logic         sdo;    // serial data out
      logic         ascend; // streaming direction, 1 = up
      logic         hold;   // streaming address hold
      logic [6:0]   src;    // sync ref control, bit 7 reserved
      logic [3:0]   cic;    // clock input control, 7:4 reserved
   } scsr_spi_state_t;

   localparam scsr_spi_state_t R_RST = '{
      st: SCSR_IDLE, sclk_q: 1'b0, cnt: 5'h00, rd: 1'b0, addr: 15'h0000,
      rx: 7'h00, tx: 8'h00, sdo: 1'b0, ascend: ASCEND_RST, hold: HOLD_RST,
      src: SRC_RST, cic: CIC_RST};

   scsr_spi_state_t       r;
   scsr_spi_state_t       next_r;
   logic [3:0]            pin_s;     // synced sclk, inverted select, sdi, sync-ref
   logic                  sclk;      // synced serial clock
   logic                  cs_n;      // synced chip select
   logic                  sdi;       // synced serial data in
   logic                  rise;      // serial clock rising edge
   logic                  fall;      // serial clock falling edge
   logic [14:0]           step_addr; // address of next streamed byte
   logic [14:0]           hdr_addr;  // address as the header completes
   logic [7:0]            wr_byte;   // byte as its last bit arrives
   logic [POS_W-1:0]      pos;       // captured position status

   // all four pins come from outside this clock domain; select goes in
   // inverted so a cleared synchroniser reads deselected, not a false frame
   scsr_pin_sync #(
      .W(4)
   ) u_sync (
      .core_clk_i (core_clk_i),
      .arst_n_i   (arst_n_i),
      .raw_i      ({sysref_i, spi_sdi_i, ~spi_cs_n_i, spi_sclk_i}),
      .sync_o     (pin_s)
   );

   assign sclk = pin_s[0];
   assign cs_n = ~pin_s[1]; // undo the inversion at the synchroniser
   assign sdi  = pin_s[2];
   assign rise = sclk & ~r.sclk_q;
   assign fall = ~sclk & r.sclk_q;

   // sync-ref datapath steered by both control registers
   scsr_sysref_path u_sysref (
      .core_clk_i (core_clk_i),
      .arst_n_i   (arst_n_i),
      .sysref_i   (pin_s[3]),
      .recv_en_i  (r.src[SRC_RECV_BIT]),
      .proc_en_i  (r.src[SRC_PROC_BIT]),
      .flip_i     (r.cic[CIC_FLIP_BIT]),
      .fine_i     (r.src[SRC_FINE_BIT]),
      .sel_i      (r.src[SRC_SEL_MSB:0]),
      .ts_en_i    (r.cic[CIC_TS_BIT] & output_timestamp_enable_i),
      .sample_i   (sample_i),
      .sample_o   (sample_o),
      .event_o    (sysref_event_o),
      .pos_o      (pos)
   );

   // read-back mux; unmapped addresses read zero
   function automatic logic [7:0] rd_byte(input logic [14:0] a,
                                          input scsr_spi_state_t s,
                                          input logic [POS_W-1:0] p);
      logic [7:0] b;
      b = 8'h00;
      if (a == ADDR_CFG_A) begin
         b[CFG_A_ASCEND_BIT] = s.ascend;
         b[CFG_A_SDO_BIT]    = 1'b1;
      end else if (a == ADDR_ID_LO) begin
         b = MAKER_ID[7:0];
      end else if (a == ADDR_ID_HI) begin
         b = MAKER_ID[15:8];
      end else if (a == ADDR_USR) begin
         b[USR_HOLD_BIT] = s.hold;
      end else if (a == ADDR_SRC) begin
         b = {1'b0, s.src};
      end else if (a == ADDR_CIC) begin
         b = {4'h0, s.cic};
      end else if (a == ADDR_POS0) begin
         b = p[7:0];
      end else if (a == ADDR_POS1) begin
         b = p[15:8];
      end else if (a == ADDR_POS2) begin
         b = p[23:16];
      end
      return b;
   endfunction : rd_byte

   // next streamed address: held, or stepped up or down
   always_comb begin
      if (r.hold) begin
         step_addr = r.addr;
      end else if (r.ascend) begin
         step_addr = 15'(r.addr + ADDR_STEP);
      end else begin
         step_addr = 15'(r.addr - ADDR_STEP);
      end
   end

   assign hdr_addr = {r.addr[13:0], sdi};
   assign wr_byte  = {r.rx, sdi};

   // serial frame engine; data in on rising, data out on falling edge
   always_comb begin
      next_r        = r;
      next_r.sclk_q = sclk;
      if (cs_n) begin
         // deselect ends the frame wherever it stands
         next_r.st  = SCSR_IDLE;
         next_r.cnt = 5'h00;
      end else begin
         case (r.st)
            SCSR_IDLE: begin
               // select needs one cycle of setup before the first edge
               next_r.st  = SCSR_HDR;
               next_r.cnt = 5'h00;
            end
            SCSR_HDR: begin
               // header shifts in msb first; the read flag leaves bit 14 last
               if (rise) begin
                  next_r.rd   = r.addr[14];
                  next_r.addr = hdr_addr;
                  next_r.cnt  = 5'(r.cnt + 5'h01);
                  if (r.cnt == HDR_LAST) begin
                     next_r.st  = SCSR_DATA;
                     next_r.cnt = 5'h00;
                     next_r.tx  = rd_byte(hdr_addr, r, pos);
                  end
               end
            end
            SCSR_DATA: begin
               if (rise) begin
                  next_r.rx  = wr_byte[6:0];
                  next_r.cnt = 5'(r.cnt + 5'h01);
                  // last bit of a byte: commit the write, then step the address
                  if (r.cnt == BYTE_LAST) begin
                     next_r.cnt = 5'h00;
                     if (!r.rd) begin
                        // writes land in the addressed register
                        if (r.addr == ADDR_CFG_A) begin
                           next_r.ascend = wr_byte[CFG_A_ASCEND_BIT];
                        end else if (r.addr == ADDR_USR) begin
                           next_r.hold = wr_byte[USR_HOLD_BIT];
                        end else if (r.addr == ADDR_SRC) begin
                           next_r.src = wr_byte[6:0];
                        end else if (r.addr == ADDR_CIC) begin
                           next_r.cic = wr_byte[3:0];
                        end
                        // maker code and status bytes ignore writes
                     end
                     next_r.addr = step_addr;
                     next_r.tx   = rd_byte(step_addr, r, pos);
                  end
               end else if (fall) begin
                  // next read bit leaves on the falling edge, held until the next fall
                  next_r.sdo = r.tx[7];
                  next_r.tx  = {r.tx[6:0], 1'b0};
               end
            end
            default: begin
               next_r.st = SCSR_IDLE;
            end
         endcase
      end
   end

   // single state register; every control field has a constant reset
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         r <= R_RST;
      end else begin
         r <= next_r;
      end
   end

   // data out is driven only while a read frame is in its data phase
   assign spi_sdo_o                    = r.sdo;
   assign spi_sdo_oe_n_o               = ~(~cs_n & r.rd & (r.st == SCSR_DATA));
   assign sysref_receiver_enable_o     = r.src[SRC_RECV_BIT];
   assign device_clock_dc_input_mode_o = r.cic[CIC_DEVCLK_BIT];
   assign sysref_dc_input_mode_o       = r.cic[CIC_SRDC_BIT];

   sequence s_byte_end;
      r.st == SCSR_DATA && !cs_n && rise && r.cnt == BYTE_LAST;
   endsequence

   sequence s_hdr_end;
      r.st == SCSR_HDR && !cs_n && rise && r.cnt == HDR_LAST;
   endsequence

   property p_addr_up;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      s_byte_end ##0 (!r.hold && r.ascend) |=> r.addr == $past(r.addr) + 15'h0001;
   endproperty
   a_addr_up: assert property (p_addr_up)
      else $error("streaming address did not step up");

   property p_addr_down;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      s_byte_end ##0 (!r.hold && !r.ascend) |=> r.addr == $past(r.addr) - 15'h0001;
   endproperty
   a_addr_down: assert property (p_addr_down)
      else $error("streaming address did not step down");

   property p_addr_hold;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      s_byte_end ##0 r.hold |=> r.addr == $past(r.addr);
   endproperty
   a_addr_hold: assert property (p_addr_hold)
      else $error("held address moved");

   property p_reset_vals;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      $rose(arst_n_i) |-> (r.src == 7'h00 && r.ascend && !sysref_event_o);
   endproperty
   a_reset_vals: assert property (p_reset_vals)
      else $error("control fields wrong after reset");

   property p_id_read;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      s_hdr_end |=> ((r.addr == ADDR_ID_LO && r.rd) |-> r.tx == MAKER_ID[7:0]);
   endproperty
   a_id_read: assert property (p_id_read)
      else $error("maker code read back wrong");

   property p_cic_write;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      s_byte_end ##0 (!r.rd && r.addr == ADDR_CIC) |=>
         {device_clock_dc_input_mode_o, sysref_dc_input_mode_o, r.cic[0]}
            == $past({r.rx[1:0], sdi});
   endproperty
   a_cic_write: assert property (p_cic_write)
      else $error("clock input control write not applied");

   property p_src_write;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      s_byte_end ##0 (!r.rd && r.addr == ADDR_SRC) |=> r.src == $past(wr_byte[6:0]);
   endproperty
   a_src_write: assert property (p_src_write)
      else $error("sync ref control write not applied");

   property p_hold_write;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      s_byte_end ##0 (!r.rd && r.addr == ADDR_USR) |=> r.hold == $past(sdi);
   endproperty
   a_hold_write: assert property (p_hold_write)
      else $error("address hold write not applied");

   property p_id_hi_read;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      s_byte_end ##0 (r.rd && r.addr == ADDR_ID_LO && !r.hold && r.ascend) |=>
         r.tx == MAKER_ID[15:8];
   endproperty
   a_id_hi_read: assert property (p_id_hi_read)
      else $error("maker code high byte not streamed after low byte");

   property p_pos_read;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      s_hdr_end |=> ((r.addr == ADDR_POS0 && r.rd) |-> r.tx == $past(pos[7:0]));
   endproperty
   a_pos_read: assert property (p_pos_read)
      else $error("position status low byte read back wrong");
endmodule : scsr_spi_regs

// ### verilog/scsr_sysref_path.sv
`timescale 1ns/1ps
// sync-ref receive path: polarity, capture delay, position window,
// processor event and timestamp insertion on the output samples
module scsr_sysref_path (
   input  wire logic                          core_clk_i,
   input  wire logic                          arst_n_i,
   input  wire logic                          sysref_i,
   input  wire logic                          recv_en_i,
   input  wire logic                          proc_en_i,
   input  wire logic                          flip_i,
   input  wire logic                          fine_i,
   input  wire logic [3:0]                    sel_i,
   input  wire logic                          ts_en_i,
   input  wire logic [scsr_pkg::SAMPLE_W-1:0] sample_i,
   output logic      [scsr_pkg::SAMPLE_W-1:0] sample_o,
   output logic                               event_o,
   output logic      [scsr_pkg::POS_W-1:0]    pos_o
);
   import scsr_pkg::*;

   typedef struct packed {
      logic [HIST_W-1:0]   hist;   // past receiver samples, bit 0 newest
      logic                tap_q;  // delayed tap, last cycle
      logic                ev;     // processor event pulse
      logic [POS_W-1:0]    pos;    // captured edge window
      logic [SAMPLE_W-1:0] sample; // outgoing sample
   } scsr_sr_t;

   scsr_sr_t          r;
   scsr_sr_t          next_r;
   logic              rx;   // receiver output after polarity
   logic              tap;  // delayed copy chosen by select
   logic [POS_W-1:0]  win;  // window at current step size

   // receiver gated by its enable; polarity flip applied here
   assign rx  = recv_en_i & (sysref_i ^ flip_i);
   // fine step uses every tap, coarse step every second tap
   assign tap = fine_i ? r.hist[{1'b0, sel_i}] : r.hist[{sel_i, 1'b0}];

   genvar g;
   generate
      for (g = 0; g < POS_W; g++) begin : g_win
         assign win[g] = fine_i ? r.hist[g] : r.hist[2*g];
      end
   endgenerate

   // history, event, position and sample update
   always_comb begin
      next_r       = r;
      next_r.hist  = {r.hist[HIST_W-2:0], rx};
      next_r.tap_q = tap;
      // events only while the processor is enabled
      next_r.ev    = proc_en_i & tap & ~r.tap_q;
      // capture where the edge fell when the receiver sees it rise
      if (rx && !r.hist[0]) begin
         next_r.pos = win;
      end
      // timestamp replaces the sample lsb only when both enables are set
      if (ts_en_i) begin
         next_r.sample = {sample_i[SAMPLE_W-1:1], tap};
      end else begin
         next_r.sample = sample_i;
      end
   end

   // single state register
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign sample_o = r.sample;
   assign event_o  = r.ev;
   assign pos_o    = r.pos;

   property p_event_gated;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      event_o |-> $past(proc_en_i);
   endproperty
   a_event_gated: assert property (p_event_gated)
      else $error("sync-ref event while processor disabled");

   property p_fine_tap;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      (fine_i && sel_i == 4'h3) |-> tap == $past(rx, 4);
   endproperty
   a_fine_tap: assert property (p_fine_tap)
      else $error("fine step tap delay wrong");

   property p_coarse_tap;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      (!fine_i && sel_i == 4'h3) |-> tap == $past(rx, 7);
   endproperty
   a_coarse_tap: assert property (p_coarse_tap)
      else $error("coarse step tap delay wrong");

   property p_pos_capture;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      (rx && !r.hist[0] && fine_i) |=> pos_o == $past(r.hist[POS_W-1:0]);
   endproperty
   a_pos_capture: assert property (p_pos_capture)
      else $error("position window not captured");

   property p_timestamp;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      ts_en_i |=> sample_o[0] == $past(tap);
   endproperty
   a_timestamp: assert property (p_timestamp)
      else $error("timestamp missing on sample lsb");
endmodule : scsr_sysref_path
